// >>> src/nvsq_host.sv
/*
  host controller that drives the nvsram pins to start software store,
  software recall and line-requested store, and watches the store/busy line.
  assumes store_busy_line is open drain with a pull-up outside this module,
  and that ordinary sram traffic is idle while a command runs.
*/
`timescale 1ns/1ps
`default_nettype none
module nvsq_host (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    cmd_valid,
  input  wire nvsq_pkg::nvsq_op_type   cmd_op,
  input  wire logic                    suppress_autostore,
  output logic                         cmd_ready,
  output logic                         cmd_done,
  output logic                         busy_seen,
  output nvsq_pkg::nvsq_pins_type      pins,
  output nvsq_pkg::nvsq_od_type        store_busy_line_drv,
  input  wire logic                    store_busy_line_in
);
  typedef enum logic [2:0] {
    NVSQ_ST_IDLE  = 3'b000,
    NVSQ_ST_SETUP = 3'b001,
    NVSQ_ST_LOW   = 3'b011,
    NVSQ_ST_HIGH  = 3'b010,
    NVSQ_ST_WAIT  = 3'b110,
    NVSQ_ST_HWLOW = 3'b111,
    NVSQ_ST_RELSE = 3'b100
  } nvsq_state_type;

  typedef struct packed {
    nvsq_state_type        st;
    nvsq_pkg::nvsq_op_type op;
    logic [2:0]            step;
    logic [nvsq_pkg::CNT_W-1:0] cnt;
    nvsq_pkg::nvsq_pins_type    pins;
    logic                  drive_low;
    logic                  drive_high;
    logic                  done;
    // samples still to come before the synchronised line can be trusted
    logic [1:0]            settle;
  } nvsq_regs_type;

  nvsq_regs_type s_r;
  nvsq_regs_type s_nxt;
  logic          line_s;

  nvsq_sync u_sync (
    .clk    (clk),
    .resetn (resetn),
    .d      (store_busy_line_in),
    .q      (line_s)
  );

  // store and recall share the sequence; only the last address and the wait differ
  function automatic logic is_recall(input nvsq_pkg::nvsq_op_type op);
    is_recall = (op == nvsq_pkg::NVSQ_OP_RECALL);
  endfunction

  // address of step n of the initiation sequence
  function automatic logic [nvsq_pkg::ADDR_W-1:0] seq_addr(input logic [2:0] n,
                                                           input nvsq_pkg::nvsq_op_type op);
    unique case (n)
      3'h0:    seq_addr = nvsq_pkg::SEQ_A0;
      3'h1:    seq_addr = nvsq_pkg::SEQ_A1;
      3'h2:    seq_addr = nvsq_pkg::SEQ_A2;
      3'h3:    seq_addr = nvsq_pkg::SEQ_A3;
      3'h4:    seq_addr = nvsq_pkg::SEQ_A4;
      default: seq_addr = is_recall(op) ? nvsq_pkg::SEQ_RECALL : nvsq_pkg::SEQ_STORE;
    endcase
  endfunction

  // counts load n-1 because the zero value is a cycle of its own
  function automatic logic [nvsq_pkg::CNT_W-1:0] cyc(input int n);
    cyc = nvsq_pkg::CNT_W'(n - 1);
  endfunction

  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    // the synchroniser resets to the idle level; after a reset in mid-store
    // the real line may still be low, so wait until it has been sampled
    if (s_r.settle != 2'h0) begin
      s_nxt.settle = s_r.settle - 2'h1;
    end
    unique case (s_r.st)
      NVSQ_ST_IDLE: begin
        s_nxt.pins.chip_en_n  = 1'b1;
        s_nxt.pins.write_en_n = 1'b1;
        // high drive only when the user asks to overpower the power-fail pull
        s_nxt.drive_high      = suppress_autostore;
        if (cmd_valid && cmd_ready && cmd_op != nvsq_pkg::NVSQ_OP_NONE) begin
          s_nxt.op         = cmd_op;
          s_nxt.step       = 3'h0;
          s_nxt.drive_high = 1'b0;
          if (cmd_op == nvsq_pkg::NVSQ_OP_HWSTORE) begin
            s_nxt.st        = NVSQ_ST_HWLOW;
            s_nxt.drive_low = 1'b1;
            s_nxt.cnt       = cyc(nvsq_pkg::HW_PULSE_CYC + 1);
          end else begin
            // sequence runs back to back, no other access in between
            s_nxt.st        = NVSQ_ST_SETUP;
            s_nxt.pins.addr = seq_addr(3'h0, cmd_op);
            s_nxt.cnt       = cyc(nvsq_pkg::CS_PULSE_CYC);
          end
        end
      end
      NVSQ_ST_SETUP: begin
        if (s_r.cnt == '0) begin
          s_nxt.st             = NVSQ_ST_LOW;
          s_nxt.pins.chip_en_n = 1'b0;
          s_nxt.pins.write_en_n = 1'b1;
          s_nxt.cnt            = cyc(nvsq_pkg::CS_PULSE_CYC);
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      NVSQ_ST_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.st             = NVSQ_ST_HIGH;
          s_nxt.pins.chip_en_n = 1'b1;
          s_nxt.cnt            = cyc(nvsq_pkg::CS_PULSE_CYC);
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      NVSQ_ST_HIGH: begin
        if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end else if (s_r.step == nvsq_pkg::SEQ_LAST) begin
          // device now busy; wait its cycle time before touching sram
          s_nxt.st  = NVSQ_ST_WAIT;
          s_nxt.cnt = is_recall(s_r.op)
                      ? cyc(nvsq_pkg::RECALL_CYC) : cyc(nvsq_pkg::STORE_CYC);
        end else begin
          s_nxt.step      = s_r.step + 3'h1;
          s_nxt.pins.addr = seq_addr(s_r.step + 3'h1, s_r.op);
          s_nxt.st        = NVSQ_ST_SETUP;
          s_nxt.cnt       = cyc(nvsq_pkg::CS_PULSE_CYC);
        end
      end
      NVSQ_ST_HWLOW: begin
        // hold the line longer than the minimum pulse, then let go
        if (s_r.cnt == '0) begin
          s_nxt.st        = NVSQ_ST_WAIT;
          s_nxt.drive_low = 1'b0;
          s_nxt.cnt       = cyc(nvsq_pkg::STORE_CYC);
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      NVSQ_ST_WAIT: begin
        // a software store is skipped only at low cap, yet its full time always runs;
        // a line store may be skipped by the device (no write, low cap):
        // end early once the line is seen high again
        if (s_r.cnt == '0 ||
            (s_r.op == nvsq_pkg::NVSQ_OP_HWSTORE && line_s &&
             s_r.cnt < cyc(nvsq_pkg::STORE_CYC) - 1'b1)) begin
          s_nxt.st = NVSQ_ST_RELSE;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      NVSQ_ST_RELSE: begin
        // device stays disabled until the line goes high
        if (line_s) begin
          s_nxt.st   = NVSQ_ST_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default: begin
        s_nxt.st = NVSQ_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= '{st: NVSQ_ST_IDLE, op: nvsq_pkg::NVSQ_OP_NONE, step: 3'h0, cnt: '0,
               pins: '{addr: '0, chip_en_n: 1'b1, write_en_n: 1'b1, out_en_n: 1'b1},
               drive_low: 1'b0, drive_high: 1'b0, done: 1'b0,
               settle: 2'h2};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_ready              = (s_r.st == NVSQ_ST_IDLE) && line_s && (s_r.settle == 2'h0);
  assign cmd_done               = s_r.done;
  assign busy_seen              = ~line_s;
  assign pins                   = s_r.pins;
  // open drain: only ever drive low, except the strong-high override;
  // while that override stands the device's own busy pull is hidden, which
  // the user accepts by asking for it
  assign store_busy_line_drv.o  = s_r.drive_high & ~s_r.drive_low;
  assign store_busy_line_drv.oe = s_r.drive_low | s_r.drive_high;
endmodule // nvsq_host
`default_nettype wire

// >>> src/nvsq_pkg.sv
/*
  package of the nonvolatile store/recall host controller: sequence
  addresses, pin bundles, timing counts and operation encodings.
  assumes a 25 MHz clock and an 11-bit parallel sram address bus.
*/
package nvsq_pkg;
  localparam int  CLK_MHZ          = 25;
  localparam int  ADDR_W           = 11;
  localparam int  DATA_W           = 8;
  // chip-select low/high and address setup per sequence read, in ns
  localparam int  CS_PULSE_NS      = 40;
  localparam int  CS_PULSE_CYC     = (CS_PULSE_NS * CLK_MHZ + 999) / 1000;
  // hardware store request: low pulse width, ns
  localparam int  HW_PULSE_NS      = 80;
  localparam int  HW_PULSE_CYC     = (HW_PULSE_NS * CLK_MHZ + 999) / 1000;
  // store cycle time 10 ms, recall cycle time 20 us
  localparam int  STORE_US         = 10000;
  localparam int  STORE_CYC        = STORE_US * CLK_MHZ;
  localparam int  RECALL_US        = 20;
  localparam int  RECALL_CYC       = RECALL_US * CLK_MHZ;
  localparam int  CNT_W            = 20;

  localparam logic [ADDR_W-1:0] SEQ_A0     = 11'h000;
  localparam logic [ADDR_W-1:0] SEQ_A1     = 11'h555;
  localparam logic [ADDR_W-1:0] SEQ_A2     = 11'h2aa;
  localparam logic [ADDR_W-1:0] SEQ_A3     = 11'h7ff;
  localparam logic [ADDR_W-1:0] SEQ_A4     = 11'h0f0;
  localparam logic [ADDR_W-1:0] SEQ_STORE  = 11'h70f;
  localparam logic [ADDR_W-1:0] SEQ_RECALL = 11'h70e;
  localparam logic [2:0]        SEQ_LAST   = 3'h5;

  typedef enum logic [1:0] {
    NVSQ_OP_NONE   = 2'h0,
    NVSQ_OP_STORE  = 2'h1,
    NVSQ_OP_RECALL = 2'h2,
    NVSQ_OP_HWSTORE = 2'h3
  } nvsq_op_type;

  // sram-side pins driven by the controller (active-low strobes)
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_en_n;
    logic              write_en_n;
    logic              out_en_n;
  } nvsq_pins_type;

  typedef struct packed {
    logic o;
    logic oe;
  } nvsq_od_type;
endpackage : nvsq_pkg

// >>> src/nvsq_sync.sv
/*
  two-flop synchroniser for a level from a pin.
  assumes the input is asynchronous to clk; reset value is high (idle line).
*/
`timescale 1ns/1ps
`default_nettype none
module nvsq_sync (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic d,
  output logic      q
);
  logic [1:0] s_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_r <= 2'h3;
    end else begin
      s_r <= {s_r[0], d};
    end
  end
  assign q = s_r[1];
endmodule // nvsq_sync
`default_nettype wire

// >>> testbench/nvsq_dev_model.sv
/* behavioural nvsram device: sequence detector and store/busy pull-down.
   assumes the bench wires the line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module nvsq_dev_model #(
  parameter int STORE_T = 300,
  // strapping: 0 turns off only the power-fail store
  parameter bit AUTO_EN = 1'b1
) (
  input  wire logic                    clk,
  input  wire logic                    supply_low,
  input  wire nvsq_pkg::nvsq_pins_type pins,
  input  wire logic                    line,
  input  wire logic                    cap_low,
  output logic                         pull_low
);
  logic [10:0] seq_a [5] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0};
  int step = 0;
  int busy = 0;
  int stores = 0;
  int recalls = 0;
  bit st = 0;
  int aborts = 0;
  int pf = 0;
  bit pf_arm = 0;
  // address is clocked by chip-enable rising; deaf while busy or line low
  always @(posedge pins.chip_en_n) begin
    if (busy == 0 && line && pins.write_en_n) begin
      if (step == 5 && pins.addr inside {11'h70f, 11'h70e}) begin
        st = pins.addr == 11'h70f;
        stores += st && !cap_low;
        recalls += !st;
        busy = (st && cap_low) ? 0 : st ? STORE_T : 40;
        step = 0;
      end else if (step < 5 && pins.addr == seq_a[step]) begin
        step++;
      end else begin
        step = (pins.addr == 11'h000) ? 1 : 0;
      end
    end
  end
  // no write ever reaches this model, so line requests never store
  // falling edge: the line never moves while the host samples it
  always @(negedge clk) begin
    if (busy > 0)
      busy--;
    // power-fail onset: pull for two cycles, give up if the line stays high
    if (pf == 1 && line)
      aborts++;
    if (pf > 0)
      pf--;
    else if (AUTO_EN && supply_low && !pf_arm)
      pf = 2;
    pf_arm = supply_low;
  end
  assign pull_low = (st && busy > 0) || pf > 0;
endmodule // nvsq_dev_model
`default_nettype wire

// >>> testbench/nvsq_host_chk.sv
/* port assertions for nvsq_host.
   assumes bind to the nvsq_host module. */
`timescale 1ns/1ps
`default_nettype none
module nvsq_host_chk (
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    cmd_valid,
  input wire nvsq_pkg::nvsq_op_type   cmd_op,
  input wire logic                    suppress_autostore,
  input wire logic                    cmd_ready,
  input wire logic                    cmd_done,
  input wire logic                    busy_seen,
  input wire nvsq_pkg::nvsq_pins_type pins,
  input wire nvsq_pkg::nvsq_od_type   store_busy_line_drv,
  input wire logic                    store_busy_line_in
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic take = cmd_valid && cmd_ready;
  sequence s_read0;
    (pins.chip_en_n && pins.addr == 11'h000) ##1 !pins.chip_en_n ##1 pins.chip_en_n;
  endsequence
  sequence s_pull;
    (store_busy_line_drv.oe && !store_busy_line_drv.o) [*3] ##1 !store_busy_line_drv.oe;
  endsequence
  chk_reads_only: assert property (pins.write_en_n)
    else $error("write strobe asserted");
  chk_seq_start: assert property (take && cmd_op inside {2'h1, 2'h2} |=> s_read0)
    else $error("sequence did not open at address zero");
  chk_addr_hold: assert property ($fell(pins.chip_en_n) |->
    $stable(pins.addr) ##1 (pins.chip_en_n && $stable(pins.addr)))
    else $error("chip enable pulse malformed");
  chk_ce_busy: assert property (!pins.chip_en_n |-> !cmd_ready)
    else $error("read while idle");
  chk_line_pull: assert property (take && cmd_op == 2'h3 |=> s_pull)
    else $error("line request pulse wrong");
  chk_ready_line: assert property (cmd_ready |-> $past(store_busy_line_in, 2) &&
    pins.chip_en_n && !busy_seen)
    else $error("ready with line low");
  chk_done_line: assert property (cmd_done |-> !busy_seen ##1 !cmd_done)
    else $error("done wrong");
  chk_strong_high: assert property (store_busy_line_drv.oe && store_busy_line_drv.o |->
    $past(suppress_autostore))
    else $error("line driven high unasked");
endmodule // nvsq_host_chk
bind nvsq_host nvsq_host_chk u_nvsq_host_chk (.clk(clk), .resetn(resetn),
  .cmd_valid(cmd_valid), .cmd_op(cmd_op), .suppress_autostore(suppress_autostore),
  .cmd_ready(cmd_ready), .cmd_done(cmd_done), .busy_seen(busy_seen), .pins(pins),
  .store_busy_line_drv(store_busy_line_drv), .store_busy_line_in(store_busy_line_in));
`default_nettype wire

// >>> testbench/tb_nvsq_host.sv
/* self-checking bench of nvsq_host against a behavioural device.
   assumes package timing; a software store is cut short by reset. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: mismatch", $time); end end
module tb_nvsq_host;
  logic                    clk = 1'b0;
  logic                    resetn;
  logic                    cmd_valid;
  nvsq_pkg::nvsq_op_type   cmd_op;
  logic                    suppress_autostore;
  logic                    cmd_ready;
  logic                    cmd_done;
  logic                    busy_seen;
  nvsq_pkg::nvsq_pins_type pins;
  nvsq_pkg::nvsq_od_type   drv;
  logic                    pull_low;
  logic                    supply_low;
  logic [10:0]             got_q [$];
  logic [10:0]             seq_a [5] = '{11'h000, 11'h555, 11'h2aa, 11'h7ff, 11'h0f0};
  int                      error_cnt = 0;
  int                      n_checks = 0;
  int                      exp_rec = 0;
  int                      exp_st = 0;
  int                      i;
  // pull-up on the wired line; a low driver wins, except the host's strong high
  wire logic store_busy_line = (drv.oe && drv.o) ||
                               !(pull_low || (drv.oe && !drv.o));
  always #20 clk = ~clk;
  always @(posedge pins.chip_en_n)
    got_q.push_back(pins.addr);
  nvsq_host u_nvsq_host (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .suppress_autostore(suppress_autostore), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .busy_seen(busy_seen), .pins(pins), .store_busy_line_drv(drv),
    .store_busy_line_in(store_busy_line));
  nvsq_dev_model u_nvsq_dev_model (.clk(clk), .pins(pins), .line(store_busy_line),
    .cap_low(1'b0), .supply_low(supply_low), .pull_low(pull_low));
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic limit();
    if (i == 2000) begin
      error_cnt++;
      close_out();
    end
  endtask
  task automatic do_cmd(input logic [1:0] op);
    for (i = 0; i < 2000 && cmd_ready !== 1'b1; i++)
      @(negedge clk);
    limit();
    got_q.delete();
    cmd_op = nvsq_pkg::nvsq_op_type'(op);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    if (op == 2'h0) begin
      repeat (8) @(negedge clk);
      `CHK(got_q.size(), 0)
      return;
    end
    for (i = 0; i < 2000 && cmd_done !== 1'b1 && !(op == 2'h1 && busy_seen === 1'b1); i++)
      @(negedge clk);
    limit();
    `CHK(got_q.size(), op == 2'h3 ? 0 : 6)
    for (i = 0; i < got_q.size() && i < 6; i++)
      `CHK(got_q[i], i < 5 ? seq_a[i] : (op == 2'h2 ? 11'h70e : 11'h70f))
    exp_rec += op == 2'h2;
    exp_st += op == 2'h1;
    `CHK(u_nvsq_dev_model.recalls, exp_rec)
    `CHK(u_nvsq_dev_model.stores, exp_st)
  endtask
  initial begin
    logic [1:0] op;
    i = $urandom(38);
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = nvsq_pkg::NVSQ_OP_NONE;
    suppress_autostore = 1'b0;
    supply_low = 1'b0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    do_cmd(2'h2);
    do_cmd(2'h3);
    do_cmd(2'h0);
    repeat (8) begin
      op = 2'($urandom_range(3, 1));
      do_cmd(op == 2'h1 ? 2'h0 : op);
    end
    suppress_autostore = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(drv, 2'h3)
    supply_low = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(u_nvsq_dev_model.aborts, 1)
    suppress_autostore = 1'b0;
    supply_low = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(drv, 2'h0)
    supply_low = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(u_nvsq_dev_model.aborts, 1)
    supply_low = 1'b0;
    do_cmd(2'h1);
    `CHK(cmd_ready, 1'b0)
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(cmd_ready, 1'b0)
    do_cmd(2'h2);
    `CHK(busy_seen, 1'b0)
    close_out();
  end
endmodule // tb_nvsq_host
`default_nettype wire
